/* File: hdl/fdc_cmd_decoder.v */
// floppy command decoder: seek, scan, sense, set track, specify, verify
// ----------------------------------------------------------------
// How it works
// - relative seek: two bytes, steps head in/out by count, no result
// - scan compares host bytes with disk bytes, never stores them
// - seek: opcode, head/drive, new track; steps there, no result
// - fourth seek byte carries track high nibble only when extended
// - sense drive status returns one byte, status register 3
// - sense interrupt returns status 0 then present track
// - third sense interrupt byte is track high nibble when extended
// - set track reads or writes selected present-track byte, one result
// - specify loads step, motor timings and dma bit; no result
// - verify reads sectors and checks them, no data to host
// - verify takes nine bytes; last is count or length by flag
// - one present-track value per drive, read by sense and set track
// - unknown opcode returns single byte 80h, no execution
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "fdc_cmd_regs.vh"
module fdc_cmd_decoder #(
	parameter TRACK_W = 12
) (
	input  wire       REF_CLK,
	input  wire       RSTN,
	input  wire [7:0] CMD_DATA,
	input  wire       CMD_WRITE,
	input  wire       RES_READ,
	input  wire       EXT_TRACK_RANGE,
	input  wire [7:0] DRIVE_STATUS,
	input  wire       STEP_DONE,
	input  wire       DISK_DONE,
	input  wire       DISK_ERROR,
	input  wire [7:0] DISK_BYTE,
	input  wire       DISK_BYTE_VALID,
	input  wire [7:0] HOST_BYTE,
	output reg        READY,
	output reg        DIR_TO_HOST,
	output reg  [7:0] RES_DATA,
	output reg        BUSY,
	output reg        SEEK_START,
	output reg        SEEK_DIR_IN,
	output reg  [TRACK_W-1:0] SEEK_COUNT,
	output reg  [1:0] DRIVE_SEL,
	output reg        HEAD_SEL,
	output reg        DISK_START,
	output reg        DISK_VERIFY,
	output reg        HOST_BYTE_REQ,
	output reg  [3:0] STEP_RATE,
	output reg  [3:0] MOTOR_OFF,
	output reg  [6:0] MOTOR_ON,
	output reg        NON_DMA,
	output reg        SCAN_MATCH
);
	// ----------------------------------------------------------------
	// state codes and command kinds
	// ----------------------------------------------------------------
	localparam S_IDLE = 3'd0;
	localparam S_CMD  = 3'd1;
	localparam S_SEEK = 3'd2;
	localparam S_DISK = 3'd3;
	localparam S_RES  = 3'd4;
	localparam K_REL  = 4'd0;
	localparam K_SEEK = 4'd1;
	localparam K_SEQ  = 4'd2;
	localparam K_SHE  = 4'd3;
	localparam K_SLE  = 4'd4;
	localparam K_SDRV = 4'd5;
	localparam K_SINT = 4'd6;
	localparam K_STRK = 4'd7;
	localparam K_SPEC = 4'd8;
	localparam K_VER  = 4'd9;
	localparam K_BAD  = 4'd15;

	// opcode classification, used for decode and byte-count lookup
	function [3:0] kind_of;
		input [7:0] op;
		begin
			// bit 6 is the step direction of relative seek only
			if (op[4:0] == `OP_RELSEEK_LO && !op[5] && (op[7] || !op[6]))
				kind_of = op[7] ? K_REL : K_SEEK;
			else if (op[4:0] == `OP_SCAN_EQ)
				kind_of = K_SEQ;
			else if (op[4:0] == `OP_SCAN_HE)
				kind_of = K_SHE;
			else if (op[4:0] == `OP_SCAN_LE)
				kind_of = K_SLE;
			else if (op == `OP_SENSE_DRV)
				kind_of = K_SDRV;
			else if (op == `OP_SENSE_INT)
				kind_of = K_SINT;
			else if (op[5:0] == `OP_SET_TRK_LO && !op[7])
				kind_of = K_STRK;
			else if (op == `OP_SPECIFY)
				kind_of = K_SPEC;
			else if (op[4:0] == `OP_VERIFY)
				kind_of = K_VER;
			else
				kind_of = K_BAD;
		end
	endfunction

	function [3:0] len_of;
		input [3:0] k;
		input       ext;
		begin
			case (k)
				K_REL:  len_of = `LEN_RELSEEK;
				K_SEEK: len_of = ext ? `LEN_SEEK_EXT : `LEN_SEEK;
				K_SEQ, K_SHE, K_SLE: len_of = `LEN_SCAN;
				K_SDRV: len_of = `LEN_SENSE_DRV;
				K_SINT: len_of = `LEN_SENSE_INT;
				K_STRK: len_of = `LEN_SET_TRK;
				K_SPEC: len_of = `LEN_SPECIFY;
				K_VER:  len_of = `LEN_VERIFY;
				default: len_of = 4'h1;
			endcase
		end
	endfunction

	reg [2:0]  state_reg;
	reg [3:0]  kind_reg;
	reg [7:0]  op_reg;
	reg [3:0]  idx_reg;
	reg [3:0]  len_reg;
	reg [7:0]  b1_reg;
	reg [7:0]  b2_reg;
	reg [7:0]  st0_reg;
	reg [7:0]  res_buf [0:6];
	reg [2:0]  res_n_reg;
	reg [2:0]  res_i_reg;
	reg [TRACK_W-1:0] ptr_reg [0:3];
	reg        scan_ok_reg;
	reg        count_mode_reg;
	reg [7:0]  last_reg;
	wire [3:0] kind_now = kind_of(CMD_DATA);
	// two-byte commands end on the head byte, before b1_reg holds it
	wire       head_now = CMD_WRITE && READY && !DIR_TO_HOST &&
		state_reg == S_CMD && idx_reg == `BYTE_IDX_HEAD;
	wire [7:0] hd_byte = head_now ? CMD_DATA : b1_reg;
	wire [1:0] drv = hd_byte[1:0];
	wire [TRACK_W-1:0] cur_ptr = ptr_reg[drv];
	wire [15:0] ptr16 = {{(16-TRACK_W){1'b0}}, cur_ptr};
	// short seek ends on the track byte itself, before b2_reg holds it
	wire [11:0] new_trk = (len_reg == `LEN_SEEK_EXT) ?
		{CMD_DATA[7:4], b2_reg} : {4'h0, CMD_DATA};
	wire       byte_in = CMD_WRITE && READY && !DIR_TO_HOST;
	wire       done_cmd = byte_in && (state_reg == S_IDLE ?
		len_of(kind_now, EXT_TRACK_RANGE) == 4'h1 :
		idx_reg + 4'h1 == len_reg);
	integer    i;

	// ----------------------------------------------------------------
	// main sequencer
	// ----------------------------------------------------------------
	always @(posedge REF_CLK) begin
		if (!RSTN) begin
			state_reg <= S_IDLE;
			kind_reg <= K_BAD;
			op_reg <= 8'h00;
			idx_reg <= 4'h0;
			len_reg <= 4'h0;
			b1_reg <= 8'h00;
			b2_reg <= 8'h00;
			st0_reg <= 8'h00;
			res_n_reg <= 3'h0;
			res_i_reg <= 3'h0;
			scan_ok_reg <= 1'b1;
			count_mode_reg <= 1'b0;
			last_reg <= 8'h00;
			for (i = 0; i < 7; i = i + 1)
				res_buf[i] <= 8'h00;
			for (i = 0; i < 4; i = i + 1)
				ptr_reg[i] <= {TRACK_W{1'b0}};
			READY <= 1'b1;
			DIR_TO_HOST <= 1'b0;
			RES_DATA <= 8'h00;
			BUSY <= 1'b0;
			SEEK_START <= 1'b0;
			SEEK_DIR_IN <= 1'b0;
			SEEK_COUNT <= {TRACK_W{1'b0}};
			DRIVE_SEL <= 2'b00;
			HEAD_SEL <= 1'b0;
			DISK_START <= 1'b0;
			DISK_VERIFY <= 1'b0;
			HOST_BYTE_REQ <= 1'b0;
			STEP_RATE <= 4'h0;
			MOTOR_OFF <= 4'h0;
			MOTOR_ON <= 7'h00;
			NON_DMA <= 1'b0;
			SCAN_MATCH <= 1'b0;
		end else begin
			SEEK_START <= 1'b0;
			DISK_START <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (byte_in) begin
						op_reg <= CMD_DATA;
						kind_reg <= kind_now;
						len_reg <= len_of(kind_now, EXT_TRACK_RANGE);
						idx_reg <= 4'h1;
						BUSY <= 1'b1;
						state_reg <= S_CMD;
					end
				end
				S_CMD: begin
					if (byte_in) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == `BYTE_IDX_HEAD)
							b1_reg <= CMD_DATA;
						if (idx_reg == `BYTE_IDX_TRK)
							b2_reg <= CMD_DATA;
						if (idx_reg == `BYTE_IDX_LAST)
							last_reg <= CMD_DATA;
					end
				end
				S_SEEK: begin
					if (STEP_DONE) begin
						BUSY <= 1'b0;
						st0_reg <= `ST0_SEEK_END | {5'h00, HEAD_SEL,
							DRIVE_SEL};
						READY <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				S_DISK: begin
					// host byte compared against disk byte; nothing kept
					if (DISK_BYTE_VALID && kind_reg != K_VER) begin
						case (kind_reg)
							K_SEQ: if (DISK_BYTE != HOST_BYTE)
								scan_ok_reg <= 1'b0;
							K_SHE: if (DISK_BYTE < HOST_BYTE)
								scan_ok_reg <= 1'b0;
							default: if (DISK_BYTE > HOST_BYTE)
								scan_ok_reg <= 1'b0;
						endcase
					end
					HOST_BYTE_REQ <= kind_reg != K_VER;
					if (DISK_DONE) begin
						HOST_BYTE_REQ <= 1'b0;
						SCAN_MATCH <= scan_ok_reg && kind_reg != K_VER;
						res_buf[0] <= {1'b0, DISK_ERROR, 3'b000,
							HEAD_SEL, DRIVE_SEL};
						res_buf[1] <= {7'h00, DISK_ERROR};
						res_buf[2] <= {4'h0, scan_ok_reg, 3'b000};
						res_buf[3] <= b2_reg;
						res_buf[4] <= {7'h00, HEAD_SEL};
						res_buf[5] <= op_reg;
						res_buf[6] <= last_reg;
						res_n_reg <= `RES_DISK;
						res_i_reg <= 3'h0;
						state_reg <= S_RES;
					end
				end
				S_RES: begin
					// results leave one at a time; last read frees the port
					RES_DATA <= res_buf[res_i_reg];
					if (RES_READ && READY && DIR_TO_HOST) begin
						if (res_i_reg + 3'h1 == res_n_reg) begin
							DIR_TO_HOST <= 1'b0;
							BUSY <= 1'b0;
							state_reg <= S_IDLE;
						end else begin
							res_i_reg <= res_i_reg + 3'h1;
							RES_DATA <= res_buf[res_i_reg + 3'h1];
						end
					end else
						DIR_TO_HOST <= 1'b1;
				end
				default: state_reg <= S_IDLE;
			endcase

			// ----------------------------------------------------------------
			// command complete: execute (takes effect after last byte)
			// ----------------------------------------------------------------
			if (done_cmd) begin
				res_i_reg <= 3'h0;
				case (state_reg == S_IDLE ? kind_now : kind_reg)
					K_SINT: begin
						res_buf[0] <= st0_reg;
						res_buf[1] <= ptr16[7:0];
						res_buf[2] <= {ptr16[11:8], 4'h0};
						res_n_reg <= EXT_TRACK_RANGE ? `RES_SENSE_EXT :
							`RES_SENSE_INT;
						st0_reg <= `ST0_INVALID;
						state_reg <= S_RES;
					end
					K_BAD: begin
						res_buf[0] <= `ST0_INVALID;
						res_n_reg <= 3'h1;
						state_reg <= S_RES;
					end
					K_SDRV: begin
						res_buf[0] <= DRIVE_STATUS;
						res_n_reg <= 3'h1;
						state_reg <= S_RES;
					end
					K_STRK: begin
						// byte2 bit2 picks high or low track byte
						if (op_reg[6]) begin
							if (b1_reg[2])
								ptr_reg[drv] <= {CMD_DATA, ptr16[7:0]}
									[TRACK_W-1:0];
							else
								ptr_reg[drv] <= {ptr16[15:8], CMD_DATA}
									[TRACK_W-1:0];
							res_buf[0] <= CMD_DATA;
						end else
							res_buf[0] <= b1_reg[2] ? ptr16[15:8] :
								ptr16[7:0];
						res_n_reg <= 3'h1;
						state_reg <= S_RES;
					end
					K_SPEC: begin
						STEP_RATE <= b1_reg[7:4];
						MOTOR_OFF <= b1_reg[3:0];
						MOTOR_ON <= CMD_DATA[7:1];
						NON_DMA <= CMD_DATA[0];
						BUSY <= 1'b0;
						state_reg <= S_IDLE;
					end
					K_REL, K_SEEK: begin
						DRIVE_SEL <= drv;
						HEAD_SEL <= hd_byte[2];
						SEEK_START <= 1'b1;
						READY <= 1'b0;
						state_reg <= S_SEEK;
						if (op_reg[7]) begin
							SEEK_DIR_IN <= op_reg[6];
							SEEK_COUNT <= {{(TRACK_W-8){1'b0}}, CMD_DATA};
							ptr_reg[drv] <= op_reg[6] ?
								cur_ptr + {{(TRACK_W-8){1'b0}}, CMD_DATA} :
								cur_ptr - {{(TRACK_W-8){1'b0}}, CMD_DATA};
						end else begin
							// with extended range the last byte is the msn
							ptr_reg[drv] <= new_trk;
							SEEK_DIR_IN <= new_trk > cur_ptr;
							SEEK_COUNT <= new_trk;
						end
					end
					default: begin
						// scans and verify go to the disk engine
						DRIVE_SEL <= drv;
						HEAD_SEL <= b1_reg[2];
						DISK_START <= 1'b1;
						DISK_VERIFY <= kind_reg == K_VER;
						count_mode_reg <= b1_reg[7];
						scan_ok_reg <= 1'b1;
						last_reg <= CMD_DATA;
						state_reg <= S_DISK;
					end
				endcase
			end
		end
	end
endmodule

/* File: common/fdc_cmd_regs.vh */
// command encodings, byte counts and result values for the command decoder
`ifndef FDC_CMD_REGS_VH
`define FDC_CMD_REGS_VH
// ----------------------------------------------------------------
// opcodes, full byte or low bits only (upper bits carry per-command flags)
// ----------------------------------------------------------------
`define OP_RELSEEK_LO   5'h0F
`define OP_SEEK         8'h0F
`define OP_SCAN_EQ      5'h11
`define OP_SCAN_HE      5'h1D
`define OP_SCAN_LE      5'h19
`define OP_SENSE_DRV    8'h04
`define OP_SENSE_INT    8'h08
`define OP_SET_TRK_LO   6'h21
`define OP_SPECIFY      8'h03
`define OP_VERIFY       5'h16
`define SET_TRK_B1_HI   5'h06
// ----------------------------------------------------------------
// byte counts and constant results
// ----------------------------------------------------------------
`define LEN_RELSEEK     4'h2
`define LEN_SEEK        4'h3
`define LEN_SEEK_EXT    4'h4
`define LEN_SCAN        4'h9
`define LEN_SENSE_DRV   4'h2
`define LEN_SENSE_INT   4'h1
`define LEN_SET_TRK     4'h3
`define LEN_SPECIFY     4'h3
`define LEN_VERIFY      4'h9
`define ST0_INVALID     8'h80
`define ST0_SEEK_END    8'h20
`define RES_SENSE_INT   3'h2
`define RES_SENSE_EXT   3'h3
`define RES_DISK        3'h7
`define BYTE_IDX_HEAD   4'h1
`define BYTE_IDX_TRK    4'h2
`define BYTE_IDX_MSN    4'h3
`define BYTE_IDX_LAST   4'h8
`endif

/* File: verification/fdc_cmd_decoder_props.sv */
// port assertions for the command decoder
`timescale 1ns/100ps
module fdc_cmd_chk (
	input logic       REF_CLK,
	input logic       RSTN,
	input logic       RES_READ,
	input logic       STEP_DONE,
	input logic       DISK_DONE,
	input logic       READY,
	input logic       DIR_TO_HOST,
	input logic [7:0] RES_DATA,
	input logic       SEEK_START,
	input logic       DISK_START,
	input logic       DISK_VERIFY,
	input logic       HOST_BYTE_REQ
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// ----
	// handshake and phase ordering
	// ----
	// two cycles in, so the first result byte has landed
	result_hold_a: assert property (DIR_TO_HOST && $past(DIR_TO_HOST, 2)
		&& !RES_READ |=> DIR_TO_HOST && $stable(RES_DATA))
		else $error("result lost");
	seek_quiet_a: assert property (SEEK_START |=> !DIR_TO_HOST [*4])
		else $error("seek result");
	step_wait_a: assert property (SEEK_START |=> !READY)
		else $error("ready in seek");
	step_end_a: assert property (STEP_DONE |-> ##[1:3] READY)
		else $error("no ready");
	seek_pulse_a: assert property (SEEK_START |=> !SEEK_START)
		else $error("seek pulse");
	disk_quiet_a: assert property (DISK_START |=> !DIR_TO_HOST [*3])
		else $error("early result");
	disk_result_a: assert property (DISK_DONE |-> ##[1:3] DIR_TO_HOST)
		else $error("no result");
	verify_silent_a: assert property (DISK_VERIFY |-> !HOST_BYTE_REQ)
		else $error("verify asks host");
	scan_busy_a: assert property (HOST_BYTE_REQ |-> !DIR_TO_HOST)
		else $error("scan result");
	c_seek: cover property (SEEK_START);
	c_scan: cover property (HOST_BYTE_REQ);
	c_read: cover property (DIR_TO_HOST && RES_READ);
endmodule
bind fdc_cmd_decoder fdc_cmd_chk u_fdc_cmd_chk (.REF_CLK, .RSTN, .RES_READ,
	.STEP_DONE, .DISK_DONE, .READY, .DIR_TO_HOST, .RES_DATA, .SEEK_START,
	.DISK_START, .DISK_VERIFY, .HOST_BYTE_REQ);

/* File: verification/floppy_drive_model.sv */
// behavioural drive: step completion and a sector byte stream
`timescale 1ns/100ps
module floppy_drive_model (
	input  logic       clk,
	input  logic       slow,
	input  logic       seek_go,
	input  logic       disk_go,
	output logic       step_done = 0,
	output logic       disk_done = 0,
	output logic       valid = 0,
	output logic [7:0] data = 8'h00
);
	int i;
	// ----
	// one operation at a time, as the decoder issues them
	// ----
	initial forever begin
		@(posedge clk);
		if (seek_go === 1'b1) begin
			repeat (slow ? 20 : 5) @(posedge clk);
			#10 step_done = 1;
			@(posedge clk);
			#10 step_done = 0;
		end
		if (disk_go === 1'b1) begin
			for (i = 0; i < 4; i++) begin
				repeat (slow ? 4 : 1) @(posedge clk);
				#10 data = 8'h3c + 8'(i * 17);
				valid = 1;
				@(posedge clk);
				// stale byte flips so it never looks held
				#10 data = ~data;
				valid = 0;
			end
			@(posedge clk);
			#10 disk_done = 1;
			@(posedge clk);
			#10 disk_done = 0;
		end
	end
endmodule

/* File: verification/floppy_seek_scan_cmd_decoder_tb.sv */
// self-checking bench for the floppy command decoder
`timescale 1ns/100ps
`define CHK(a, e) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("[ERR] %0t got %h want %h", $time, a, e); \
	end \
end
module floppy_seek_scan_cmd_decoder_tb;
	localparam D = 10;
	logic        clk = 0, rstn = 0, wr_en = 0, rd_en = 0, ext = 0, slow = 0;
	logic [7:0]  cmd = 0, drv_st = 0, dbyte, res;
	logic        step_done, disk_done, valid, ready, dir, busy, seek_go;
	logic        seek_in, disk_go, vfy, hreq, hsel, non_dma, match;
	logic        seen_in, seen_vfy;
	logic [11:0] seek_cnt;
	logic [1:0]  dsel;
	logic [3:0]  step_rate, motor_off;
	logic [6:0]  motor_on;
	logic [15:0] r;
	int          mismatches = 0, check_count = 0, exp_q[$], e, d, h, t, k;
	int          ops[4] = '{8'h51, 8'hDD, 8'h19, 8'hF6};
	always #50 clk = ~clk;
	// host bytes mirror disk bytes, so every scan compares equal
	fdc_cmd_decoder u_fdc_cmd_decoder (.REF_CLK(clk), .RSTN(rstn),
		.CMD_DATA(cmd), .CMD_WRITE(wr_en), .RES_READ(rd_en),
		.EXT_TRACK_RANGE(ext), .DRIVE_STATUS(drv_st), .STEP_DONE(step_done),
		.DISK_DONE(disk_done), .DISK_ERROR(1'b0), .DISK_BYTE(dbyte),
		.DISK_BYTE_VALID(valid), .HOST_BYTE(dbyte), .READY(ready),
		.DIR_TO_HOST(dir), .RES_DATA(res), .BUSY(busy), .SEEK_START(seek_go),
		.SEEK_DIR_IN(seek_in), .SEEK_COUNT(seek_cnt), .DRIVE_SEL(dsel),
		.HEAD_SEL(hsel), .DISK_START(disk_go), .DISK_VERIFY(vfy),
		.HOST_BYTE_REQ(hreq), .STEP_RATE(step_rate), .MOTOR_OFF(motor_off),
		.MOTOR_ON(motor_on), .NON_DMA(non_dma), .SCAN_MATCH(match));
	floppy_drive_model u_floppy_drive_model (.clk(clk), .slow(slow),
		.seek_go(seek_go), .disk_go(disk_go), .step_done(step_done),
		.disk_done(disk_done), .valid(valid), .data(dbyte));
	// remember what the decoder launched
	always @(posedge clk) begin
		if (seek_go === 1'b1) seen_in <= seek_in;
		if (vfy === 1'b1) seen_vfy <= 1'b1;
	end
	// ----
	// host handshake tasks
	// ----
	task automatic wr(input logic [7:0] b);
		int n;
		n = 0;
		while (!(ready === 1'b1 && dir === 1'b0) && n < 400) begin
			@(posedge clk);
			#D n = n + 1;
		end
		cmd = b;
		wr_en = 1;
		@(posedge clk);
		#D wr_en = 0;
		@(posedge clk);
		#D;
	endtask
	// expected bytes below zero are read but not compared
	task automatic drain();
		int n, x;
		while (exp_q.size() > 0) begin
			n = 0;
			while (dir !== 1'b1 && n < 400) begin
				@(posedge clk);
				#D n = n + 1;
			end
			@(posedge clk);
			#D x = exp_q.pop_front();
			if (x >= 0) `CHK(res, x[7:0])
			rd_en = 1;
			@(posedge clk);
			#D rd_en = 0;
		end
		@(posedge clk);
		#D `CHK(dir, 1'b0)
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		mismatches++;
		wrap_up();
	end
	// ----
	// scenarios
	// ----
	initial begin
		k = $urandom(32'hb976);
		repeat (3) @(posedge clk);
		#D `CHK({ready, dir, busy, seek_go, disk_go}, 5'b10000)
		rstn = 1;
		// unknown opcode, then a write that must be ignored mid-result
		wr(8'h00);
		cmd = 8'h08;
		wr_en = 1;
		@(posedge clk);
		#D wr_en = 0;
		exp_q.push_back(8'h80);
		drain();
		r = $urandom;
		wr(8'h03);
		wr(r[15:8]);
		wr(r[7:0]);
		`CHK({step_rate, motor_off, motor_on, non_dma}, r)
		`CHK(dir, 1'b0)
		drv_st = $urandom;
		wr(8'h04);
		wr(8'h05);
		exp_q.push_back(drv_st);
		drain();
		for (e = 0; e < 2; e++) begin
			ext = e[0];
			slow = e[0];
			d = $urandom_range(3);
			h = $urandom_range(1);
			t = e ? $urandom_range(4095) : $urandom_range(255);
			wr(8'h0F);
			wr(8'(h * 4 + d));
			wr(8'(t));
			if (e) wr(8'(t >> 8 << 4));
			`CHK(dir, 1'b0)
			wr(8'h08);
			exp_q.push_back(8'h20 + h * 4 + d);
			exp_q.push_back(t & 255);
			if (e) exp_q.push_back((t >> 8) * 16);
			drain();
			`CHK(dsel, d[1:0])
		end
		for (e = 0; e < 2; e++) begin
			wr(8'h8F | 8'(e << 6));
			wr(8'h01);
			`CHK(dir, 1'b0)
			t = $urandom_range(255);
			wr(8'h61);
			wr(8'h32);
			wr(8'(t));
			exp_q.push_back(t);
			drain();
			wr(8'h21);
			wr(8'h32);
			wr(8'h00);
			exp_q.push_back(t);
			drain();
			`CHK(seen_in, e[0])
		end
		for (e = 0; e < 4; e++) begin
			seen_vfy = 0;
			slow = e[0];
			wr(ops[e][7:0]);
			wr(e == 3 ? 8'h81 : 8'h01);
			for (k = 0; k < 7; k++) wr(8'($urandom));
			for (k = 0; k < 7; k++) exp_q.push_back(-1);
			drain();
			`CHK(seen_vfy, e == 3)
			if (e < 3) `CHK(match, 1'b1)
		end
		wrap_up();
	end
endmodule
